// *** hdl/temp_limit_compare_and_dac.sv ***
`timescale 1ns/10ps
`include "temp_limit_params.svh"

module temp_limit_compare_and_dac (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic conversionDone,
	input wire logic [`TEMP_WIDTH-1:0] tempResult,
	input wire logic extendedFormat,
	input wire logic [`LIMIT_WIDTH-1:0] highLimit,
	input wire logic [`LIMIT_WIDTH-1:0] lowLimit,
	input wire logic [`LIMIT_WIDTH-1:0] upper_release_limit,
	input wire logic [`LIMIT_WIDTH-1:0] critical_temp_limit,
	input wire logic [`HYST_WIDTH-1:0] hysteresis_offset,
	input wire logic modeLoad,
	input wire logic modeExtendedIn,
	input wire temp_limit_pkg::int_mode_t modeIn,
	input wire logic status1Read,
	input wire logic extReg1Read,
	input wire logic dacLoad,
	input wire logic [`DAC_WIDTH-1:0] dacCodeIn,
	input wire logic dacPinHigh,
	input wire logic configWritten,
	output logic [`DAC_WIDTH-1:0] dacCode,
	output logic [`TEMP_WIDTH-1:0] tempReading,
	output logic highFlag,
	output logic lowFlag,
	output logic critFlag,
	output logic optExtended,
	output temp_limit_pkg::int_mode_t intMode,
	output logic int_n,
	output logic critical_temp_alert_n,
	output logic testMode
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A whole-degree limit plus a signed adjustment, scaled to sixteenths.
	// Nine bits of sum keep the extremes of limit and hysteresis from wrapping.
	function automatic logic signed [12:0] limitAt(
		input logic [`LIMIT_WIDTH-1:0] lim,
		input logic signed [4:0] adj
	);
		logic signed [8:0] sum;
		sum = $signed({lim[7], lim}) + $signed({{4{adj[4]}}, adj});
		return $signed({sum, 4'h0});
	endfunction

	logic pinSync1, pinSync2, pinSync3, configSeen;
	logic signed [12:0] tempCmp;
	logic signed [4:0] hystPlus, hystMinus;
	logic aboveHigh, aboveRelease, atOrBelowLow, aboveCrit;
	logic highRelExt, lowRelExt, critRelExt;
	logic [`CH_COUNT-1:0] trig, rel, chEnable, chRead, active, armed, flag;
	logic [`CH_COUNT-1:0] next_active, next_armed, next_flag;
	logic evaluate;

	// ----------------------------------------------------------------
	// Converter output code
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			dacCode <= `DAC_RESET_CODE;
		end else if (dacLoad) begin
			dacCode <= dacCodeIn;
		end
	end

	// ----------------------------------------------------------------
	// Test mode entry through the converter pin
	// ----------------------------------------------------------------
	// The pin level is analog-derived and asynchronous, so it is filtered
	// through three stages and acted on only when the last two agree.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pinSync1 <= 1'b0;
			pinSync2 <= 1'b0;
			pinSync3 <= 1'b0;
		end else begin
			pinSync1 <= dacPinHigh;
			pinSync2 <= pinSync1;
			pinSync3 <= pinSync2;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			configSeen <= 1'b0;
		end else if (configWritten) begin
			configSeen <= 1'b1;
		end
	end

	// Once entered, only a reset leaves test mode.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			testMode <= 1'b0;
		end else if (pinSync2 && pinSync3 && !configSeen) begin
			testMode <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			optExtended <= `OPT_EXT_RESET;
			intMode <= temp_limit_pkg::INT_ONE_TIME;
		end else if (modeLoad && !testMode) begin
			optExtended <= modeExtendedIn;
			intMode <= modeIn;
		end
	end

	// ----------------------------------------------------------------
	// Temperature presentation and comparison
	// ----------------------------------------------------------------
	// In the default format the three finest bits are dropped, so the
	// comparison sees exactly what the host reads.
	always_comb begin
		if (extendedFormat) begin
			tempCmp = $signed({tempResult[11], tempResult});
		end else begin
			tempCmp = $signed({tempResult[11], tempResult[11:3], 3'h0});
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			tempReading <= '0;
		end else if (conversionDone && !testMode) begin
			if (extendedFormat) begin
				tempReading <= tempResult;
			end else begin
				tempReading <= {{`TEMP_DEFAULT_FRAC{tempResult[11]}}, tempResult[11:3]};
			end
		end
	end

	assign hystPlus = $signed({2'b00, hysteresis_offset});
	assign hystMinus = $signed(5'h00 - {2'b00, hysteresis_offset});
	assign evaluate = conversionDone && !testMode;

	// Strict greater-than exceeds an upper limit and at-or-below releases it; the low limit trips at-or-below and releases above.
	assign aboveHigh = tempCmp > limitAt(highLimit, 5'h00);
	assign aboveRelease = tempCmp > limitAt(upper_release_limit, 5'h00);
	assign atOrBelowLow = tempCmp <= limitAt(lowLimit, 5'h00);
	assign aboveCrit = tempCmp > limitAt(critical_temp_limit, 5'h00);
	assign highRelExt = tempCmp <= limitAt(highLimit, hystMinus);
	assign lowRelExt = tempCmp > limitAt(lowLimit, hystPlus);
	assign critRelExt = tempCmp <= limitAt(critical_temp_limit, hystMinus);

	// ----------------------------------------------------------------
	// Per-channel triggers and releases
	// ----------------------------------------------------------------
	// Normal comparator releases at the high limit itself; the other normal
	// modes release at the separate release limit.
	always_comb begin
		trig[`CH_HIGH] = aboveHigh;
		trig[`CH_LOW] = atOrBelowLow;
		trig[`CH_CRIT] = aboveCrit;
		if (optExtended) begin
			rel[`CH_HIGH] = highRelExt;
		end else if (intMode == temp_limit_pkg::INT_COMPARATOR) begin
			rel[`CH_HIGH] = !aboveHigh;
		end else begin
			rel[`CH_HIGH] = !aboveRelease;
		end
		rel[`CH_LOW] = lowRelExt;
		rel[`CH_CRIT] = critRelExt;
		chEnable = {optExtended, optExtended, 1'b1};
		chRead = {extReg1Read, status1Read, status1Read};
	end

	// ----------------------------------------------------------------
	// Flag state per channel
	// ----------------------------------------------------------------
	// A conversion that sets a flag in the cycle of its read wins, so no
	// event is lost to the read.
	generate
		for (genvar ch = 0; ch < `CH_COUNT; ch++) begin : gChannel
			always_comb begin
				next_active[ch] = active[ch];
				next_armed[ch] = armed[ch];
				next_flag[ch] = flag[ch];
				if (chRead[ch]) begin
					next_flag[ch] = 1'b0;
				end
				if (!chEnable[ch]) begin
					next_active[ch] = 1'b0;
					next_armed[ch] = 1'b1;
					next_flag[ch] = 1'b0;
				end else if (evaluate) begin
					case (intMode)
						temp_limit_pkg::INT_ONE_TIME: begin
							if (armed[ch] && trig[ch]) begin
								next_flag[ch] = 1'b1;
								next_armed[ch] = 1'b0;
							end else if (rel[ch]) begin
								next_armed[ch] = 1'b1;
							end
						end
						temp_limit_pkg::INT_COMPARATOR: begin
							next_active[ch] = trig[ch] || (active[ch] && !rel[ch]);
							next_flag[ch] = next_active[ch];
						end
						default: begin
							next_active[ch] = trig[ch] || (active[ch] && !rel[ch]);
							if (next_active[ch]) begin
								next_flag[ch] = 1'b1;
							end
						end
					endcase
				end
			end

			always_ff @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					active[ch] <= 1'b0;
					armed[ch] <= 1'b1;
					flag[ch] <= 1'b0;
				end else begin
					active[ch] <= next_active[ch];
					armed[ch] <= next_armed[ch];
					flag[ch] <= next_flag[ch];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	// The pins are registered copies of the next flag state so that they
	// agree with the flag outputs in every cycle.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			highFlag <= 1'b0;
			lowFlag <= 1'b0;
			critFlag <= 1'b0;
			int_n <= 1'b1;
			critical_temp_alert_n <= 1'b1;
		end else begin
			highFlag <= next_flag[`CH_HIGH];
			lowFlag <= next_flag[`CH_LOW];
			critFlag <= next_flag[`CH_CRIT];
			int_n <= !(next_flag[`CH_HIGH] || next_flag[`CH_LOW]);
			critical_temp_alert_n <= !next_flag[`CH_CRIT];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_DAC_LOAD: assert property (@(posedge clk_sys) disable iff (reset)
		dacLoad |=> dacCode == $past(dacCodeIn))
		else $error("Converter code did not take the loaded value.");

	AST_TEST_STICKY: assert property (@(posedge clk_sys) disable iff (reset)
		testMode |=> testMode && $stable(highFlag) && $stable(tempReading))
		else $error("Test mode left or state changed during test mode.");

	AST_TEST_LOCK: assert property (@(posedge clk_sys) disable iff (reset)
		(configSeen && !testMode) |=> !testMode)
		else $error("Test mode entered after configuration write.");

	AST_NORMAL_NO_ALERT: assert property (@(posedge clk_sys) disable iff (reset)
		(!optExtended && !$past(optExtended)) |=> critical_temp_alert_n && !lowFlag)
		else $error("Alert or low flag active in a normal mode.");

	AST_REP_HIGH: assert property (@(posedge clk_sys) disable iff (reset)
		(evaluate && aboveHigh && intMode == temp_limit_pkg::INT_REPETITIVE) |=> highFlag && !int_n)
		else $error("High limit exceeded without interrupt.");

	AST_ONE_TIME_QUIET: assert property (@(posedge clk_sys) disable iff (reset)
		(intMode == temp_limit_pkg::INT_ONE_TIME && !armed[`CH_HIGH] && !highFlag
		&& !(evaluate && rel[`CH_HIGH]) && !modeLoad) |=> !highFlag ##1 !highFlag)
		else $error("One-time interrupt fired again without re-arming.");

	AST_COMP_FOLLOW: assert property (@(posedge clk_sys) disable iff (reset)
		(evaluate && !optExtended && intMode == temp_limit_pkg::INT_COMPARATOR)
		|=> highFlag == $past(aboveHigh))
		else $error("Normal comparator flag does not follow the high limit.");

	AST_CRIT_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
		(critFlag && optExtended && intMode != temp_limit_pkg::INT_COMPARATOR
		&& !extReg1Read && !modeLoad) |=> critFlag)
		else $error("Critical alert dropped before its register was read.");

	AST_READ_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
		(status1Read && !conversionDone) |=> !highFlag && !lowFlag && int_n)
		else $error("Status read did not clear flags and interrupt line.");

	AST_PIN_MATCH: assert property (@(posedge clk_sys) disable iff (reset)
		int_n == !(highFlag || lowFlag) && critical_temp_alert_n == !critFlag)
		else $error("Interrupt pins disagree with flags.");

	AST_ONLY_AT_END: assert property (@(posedge clk_sys) disable iff (reset)
		(!conversionDone && !status1Read && !extReg1Read && !modeLoad && !$past(modeLoad))
		|=> $stable(highFlag) && $stable(lowFlag) && $stable(critFlag))
		else $error("Flags changed without conversion end or read.");

	AST_EXT_CRIT_SET: assert property (@(posedge clk_sys) disable iff (reset)
		(evaluate && optExtended && aboveCrit && intMode == temp_limit_pkg::INT_REPETITIVE)
		|=> !critical_temp_alert_n)
		else $error("Critical limit exceeded without alert.");

endmodule

// *** include/temp_limit_params.svh ***
`ifndef TEMP_LIMIT_PARAMS_SVH
`define TEMP_LIMIT_PARAMS_SVH

// ----------------------------------------------------------------
// Converter output
// ----------------------------------------------------------------
`define DAC_WIDTH 8
`define DAC_LSB_UV 4880
`define DAC_RESET_CODE 8'hFF

// ----------------------------------------------------------------
// Temperature formats
// ----------------------------------------------------------------
`define TEMP_WIDTH 12
`define TEMP_DEFAULT_FRAC 3
`define LIMIT_WIDTH 8
`define HYST_WIDTH 3
`define LIMIT_FRAC_BITS 4

// ----------------------------------------------------------------
// Channel positions in the flag vector
// ----------------------------------------------------------------
`define CH_HIGH 0
`define CH_LOW 1
`define CH_CRIT 2
`define CH_COUNT 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLAG_RESET 3'h0
`define ARMED_RESET 3'h7
`define OPT_EXT_RESET 1'b0

`endif

// *** include/temp_limit_pkg.sv ***
package temp_limit_pkg;

	// ----------------------------------------------------------------
	// Interrupt behaviour within either option
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		INT_REPETITIVE,
		INT_ONE_TIME,
		INT_COMPARATOR
	} int_mode_t;

endpackage

// *** verif/host_model.sv ***
`timescale 1ns/10ps
`include "temp_limit_params.svh"

// ----------------------------------------------------------------
// Host and sensor front end seen from the block
// ----------------------------------------------------------------
module host_model #(
	parameter int FULL_HOLD = 20
) (
	input wire logic clk_sys,
	output logic conversionDone,
	output logic [`TEMP_WIDTH-1:0] tempResult,
	output logic modeLoad,
	output logic modeExtendedIn,
	output temp_limit_pkg::int_mode_t modeIn,
	output logic status1Read,
	output logic extReg1Read,
	output logic dacLoad,
	output logic [`DAC_WIDTH-1:0] dacCodeIn,
	output logic configWritten
);
	initial begin
		conversionDone = 1'b0;
		tempResult = 12'h000;
		modeLoad = 1'b0;
		modeExtendedIn = 1'b0;
		modeIn = temp_limit_pkg::INT_ONE_TIME;
		{configWritten, extReg1Read, status1Read} = 3'h0;
		dacLoad = 1'b0;
		dacCodeIn = 8'h00;
	end

	// Stale data is inverted so a late sample can never look right.
	task automatic conv(input logic [`TEMP_WIDTH-1:0] t);
		@(negedge clk_sys);
		conversionDone = 1'b1;
		tempResult = t;
		@(negedge clk_sys);
		conversionDone = 1'b0;
		tempResult = ~t;
	endtask

	task automatic pulse(input logic [2:0] sel);
		@(negedge clk_sys);
		{configWritten, extReg1Read, status1Read} = sel;
		@(negedge clk_sys);
		{configWritten, extReg1Read, status1Read} = 3'h0;
	endtask

	task automatic mode(input logic ext, input temp_limit_pkg::int_mode_t m);
		@(negedge clk_sys);
		modeLoad = 1'b1;
		modeExtendedIn = ext;
		modeIn = m;
		@(negedge clk_sys);
		modeLoad = 1'b0;
		modeExtendedIn = ~ext;
	endtask

	task automatic dac(input logic [`DAC_WIDTH-1:0] code);
		@(negedge clk_sys);
		dacLoad = 1'b1;
		dacCodeIn = code;
		@(negedge clk_sys);
		dacLoad = 1'b0;
		dacCodeIn = ~code;
	endtask

	// Fans stall at low drive, so they get a spell at full drive first.
	task automatic fan_start(input logic [`DAC_WIDTH-1:0] code);
		dac(8'hFF);
		repeat (FULL_HOLD) @(negedge clk_sys);
		dac(code);
	endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/10ps
`include "temp_limit_params.svh"

module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic conversionDone, modeLoad, modeExtendedIn, status1Read, extReg1Read, dacLoad;
	logic configWritten, extendedFormat, dacPinHigh;
	logic [`TEMP_WIDTH-1:0] tempResult, tempReading;
	logic [`LIMIT_WIDTH-1:0] highLimit, lowLimit, upper_release_limit, critical_temp_limit;
	logic [`HYST_WIDTH-1:0] hysteresis_offset;
	logic [`DAC_WIDTH-1:0] dacCodeIn, dacCode;
	temp_limit_pkg::int_mode_t modeIn, intMode;
	logic highFlag, lowFlag, critFlag, optExtended, int_n, critical_temp_alert_n, testMode;
	int err_total = 0;
	int n_checks = 0;

	always #5 clk_sys = ~clk_sys;

	temp_limit_compare_and_dac DUT (.clk_sys(clk_sys), .reset(reset),
		.conversionDone(conversionDone), .tempResult(tempResult),
		.extendedFormat(extendedFormat), .highLimit(highLimit), .lowLimit(lowLimit),
		.upper_release_limit(upper_release_limit), .critical_temp_limit(critical_temp_limit),
		.hysteresis_offset(hysteresis_offset), .modeLoad(modeLoad),
		.modeExtendedIn(modeExtendedIn), .modeIn(modeIn), .status1Read(status1Read),
		.extReg1Read(extReg1Read), .dacLoad(dacLoad), .dacCodeIn(dacCodeIn),
		.dacPinHigh(dacPinHigh), .configWritten(configWritten), .dacCode(dacCode),
		.tempReading(tempReading), .highFlag(highFlag), .lowFlag(lowFlag),
		.critFlag(critFlag), .optExtended(optExtended), .intMode(intMode), .int_n(int_n),
		.critical_temp_alert_n(critical_temp_alert_n), .testMode(testMode));

	host_model #(.FULL_HOLD(20)) host (.clk_sys(clk_sys), .conversionDone(conversionDone),
		.tempResult(tempResult), .modeLoad(modeLoad), .modeExtendedIn(modeExtendedIn),
		.modeIn(modeIn), .status1Read(status1Read), .extReg1Read(extReg1Read),
		.dacLoad(dacLoad), .dacCodeIn(dacCodeIn), .configWritten(configWritten));

	task automatic wrap_up();
		$display("TB: %0d checks, %0d mismatches", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The two pins must always mirror the flags, so every flag check covers them too.
	task automatic flags(input logic hi, input logic lo, input logic cr);
		chk("highFlag", {11'h0, hi}, {11'h0, highFlag});
		chk("lowFlag", {11'h0, lo}, {11'h0, lowFlag});
		chk("critFlag", {11'h0, cr}, {11'h0, critFlag});
		chk("int_n", {11'h0, ~(hi | lo)}, {11'h0, int_n});
		chk("critical_temp_alert_n", {11'h0, ~cr}, {11'h0, critical_temp_alert_n});
	endtask

	task automatic cv(input logic [11:0] t, input logic hi, input logic lo, input logic cr);
		host.conv(t);
		flags(hi, lo, cr);
	endtask

	task automatic rd(input logic [2:0] sel, input logic hi, input logic lo, input logic cr);
		host.pulse(sel);
		flags(hi, lo, cr);
	endtask

	task automatic test_end(input string name);
		$display("TB: test %s finished, mismatches so far %0d", name, err_total);
	endtask

	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	initial begin
		extendedFormat = 1'b1;
		dacPinHigh = 1'b0;
		highLimit = 8'h28;
		lowLimit = 8'h0A;
		upper_release_limit = 8'h23;
		critical_temp_limit = 8'h3C;
		hysteresis_offset = 3'h3;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		chk("dacCode", 12'h0FF, {4'h0, dacCode});
		chk("intMode", {10'h0, temp_limit_pkg::INT_ONE_TIME}, {10'h0, intMode});
		chk("optExtended", 12'h000, {11'h0, optExtended});
		chk("tempReading", 12'h000, tempReading);
		flags(1'b0, 1'b0, 1'b0);
		test_end("reset");
		cv(12'h191, 1'b0, 1'b0, 1'b0);
		chk("tempReading", 12'h191, tempReading);
		extendedFormat = 1'b0;
		cv(12'hFF1, 1'b0, 1'b0, 1'b0);
		chk("tempReading", 12'hFFE, tempReading);
		extendedFormat = 1'b1;
		test_end("format");
		cv(12'h290, 1'b1, 1'b0, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h290, 1'b0, 1'b0, 1'b0);
		cv(12'h230, 1'b0, 1'b0, 1'b0);
		cv(12'h280, 1'b0, 1'b0, 1'b0);
		cv(12'h281, 1'b1, 1'b0, 1'b0);
		cv(12'h400, 1'b1, 1'b0, 1'b0);
		host.conv(12'h200);
		test_end("normal one-time");
		host.mode(1'b0, temp_limit_pkg::INT_REPETITIVE);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h290, 1'b1, 1'b0, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h240, 1'b1, 1'b0, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h230, 1'b0, 1'b0, 1'b0);
		cv(12'h240, 1'b0, 1'b0, 1'b0);
		test_end("normal repetitive");
		host.mode(1'b0, temp_limit_pkg::INT_COMPARATOR);
		cv(12'h290, 1'b1, 1'b0, 1'b0);
		cv(12'h280, 1'b0, 1'b0, 1'b0);
		cv(12'h000, 1'b0, 1'b0, 1'b0);
		test_end("normal comparator");
		host.mode(1'b1, temp_limit_pkg::INT_COMPARATOR);
		chk("optExtended", 12'h001, {11'h0, optExtended});
		chk("intMode", {10'h0, temp_limit_pkg::INT_COMPARATOR}, {10'h0, intMode});
		cv(12'h290, 1'b1, 1'b0, 1'b0);
		cv(12'h260, 1'b1, 1'b0, 1'b0);
		cv(12'h250, 1'b0, 1'b0, 1'b0);
		cv(12'h0A0, 1'b0, 1'b1, 1'b0);
		cv(12'h0D0, 1'b0, 1'b1, 1'b0);
		cv(12'h0D1, 1'b0, 1'b0, 1'b0);
		cv(12'h3C1, 1'b1, 1'b0, 1'b1);
		cv(12'h3A0, 1'b1, 1'b0, 1'b1);
		cv(12'h390, 1'b1, 1'b0, 1'b0);
		test_end("extended comparator");
		host.mode(1'b1, temp_limit_pkg::INT_REPETITIVE);
		host.conv(12'h200);
		rd(3'h3, 1'b0, 1'b0, 1'b0);
		cv(12'h3C1, 1'b1, 1'b0, 1'b1);
		rd(3'h1, 1'b0, 1'b0, 1'b1);
		rd(3'h2, 1'b0, 1'b0, 1'b0);
		cv(12'h3A0, 1'b1, 1'b0, 1'b1);
		rd(3'h3, 1'b0, 1'b0, 1'b0);
		cv(12'h390, 1'b1, 1'b0, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h0A0, 1'b0, 1'b1, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h0D0, 1'b0, 1'b1, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h0D1, 1'b0, 1'b0, 1'b0);
		test_end("extended repetitive");
		host.mode(1'b1, temp_limit_pkg::INT_ONE_TIME);
		host.conv(12'h200);
		rd(3'h3, 1'b0, 1'b0, 1'b0);
		cv(12'h3C1, 1'b1, 1'b0, 1'b1);
		rd(3'h3, 1'b0, 1'b0, 1'b0);
		cv(12'h3C1, 1'b0, 1'b0, 1'b0);
		cv(12'h390, 1'b0, 1'b0, 1'b0);
		cv(12'h3C1, 1'b0, 1'b0, 1'b1);
		rd(3'h2, 1'b0, 1'b0, 1'b0);
		cv(12'h0A0, 1'b0, 1'b1, 1'b0);
		rd(3'h1, 1'b0, 1'b0, 1'b0);
		cv(12'h0D0, 1'b0, 1'b0, 1'b0);
		cv(12'h0D1, 1'b0, 1'b0, 1'b0);
		cv(12'h0A0, 1'b0, 1'b1, 1'b0);
		test_end("extended one-time");
		hysteresis_offset = 3'h7;
		lowLimit = 8'hF6;
		critical_temp_limit = 8'h7F;
		host.mode(1'b1, temp_limit_pkg::INT_COMPARATOR);
		cv(12'hF60, 1'b0, 1'b1, 1'b0);
		cv(12'hFD0, 1'b0, 1'b1, 1'b0);
		cv(12'hFD1, 1'b0, 1'b0, 1'b0);
		cv(12'h7F1, 1'b1, 1'b0, 1'b1);
		cv(12'h781, 1'b1, 1'b0, 1'b1);
		cv(12'h780, 1'b1, 1'b0, 1'b0);
		test_end("wide hysteresis");
		host.fan_start(8'h80);
		chk("dacCode", 12'h080, {4'h0, dacCode});
		host.pulse(3'h4);
		dacPinHigh = 1'b1;
		repeat (8) @(negedge clk_sys);
		chk("testMode", 12'h000, {11'h0, testMode});
		dacPinHigh = 1'b0;
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		chk("dacCode", 12'h0FF, {4'h0, dacCode});
		dacPinHigh = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk("testMode", 12'h000, {11'h0, testMode});
		@(negedge clk_sys);
		chk("testMode", 12'h001, {11'h0, testMode});
		cv(12'h290, 1'b0, 1'b0, 1'b0);
		chk("tempReading", 12'h000, tempReading);
		host.dac(8'h40);
		chk("dacCode", 12'h040, {4'h0, dacCode});
		test_end("dac and test pin");
		wrap_up();
	end
endmodule
